// ===== design/grl_port.sv
`timescale 1ns/1ps
module grl_port (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] dio_n,
  input wire logic dav_n,
  input wire logic atn_n,
  input wire logic eoi_n,
  input wire logic ren_n,
  output logic ndac_out,
  output logic ndac_oe,
  output logic nrfd_out,
  output logic nrfd_oe,
  input wire logic [4:0] my_addr,
  input wire logic local_key,
  input wire logic [7:0] panel_keys,
  input wire logic trig_wait,
  input wire logic trig_src_bus,
  input wire logic meas_busy,
  input wire logic start_done,
  input wire logic clear_ack,
  input wire logic exec_done,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  output logic [7:0] msg_len,
  output logic msg_ready,
  output logic remote_led,
  output logic lockout,
  output logic listener,
  output logic talker,
  output logic [7:0] panel_keys_out,
  output logic local_req,
  output logic meas_start,
  output logic meas_abort,
  output logic dev_clear
);
  import grl_pkg::*;

  logic [SYNC_W-1:0] sync_q;
  logic [7:0] dio_s;
  logic dav_s;
  logic atn_s;
  logic eoi_s;
  logic ren_s;
  logic key_s;
  logic key_d;
  logic [7:0] keys_s;
  grl_rl_t rl_state;
  grl_ah_t ah_state;
  logic llo_seen;
  logic [7:0] cap_byte;
  logic cap_atn;
  logic cap_eoi;
  logic busy;
  logic [7:0] wr_cnt;
  logic [7:0] mem [0:254];
  logic addr_ok;
  logic is_cmd;
  logic mla_hit;
  logic mta_hit;
  logic gtl_hit;
  logic get_hit;
  logic llo_hit;
  logic clr_hit;
  logic data_hit;
  logic key_press;
  logic holdoff;
  logic trig_ok;
  logic term_hit;

  grl_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({dio_n, dav_n, atn_n, eoi_n, ren_n, local_key, panel_keys}),
    .q(sync_q)
  );

  assign dio_s = ~sync_q[20:13];
  assign dav_s = ~sync_q[12];
  assign atn_s = ~sync_q[11];
  assign eoi_s = ~sync_q[10];
  assign ren_s = ~sync_q[9];
  assign key_s = sync_q[8];
  assign keys_s = sync_q[7:0];

  // address 31 is no address at all
  assign addr_ok = (my_addr <= ADDR_MAX);
  assign is_cmd = (ah_state == AH_DECODE) && cap_atn;
  assign mla_hit = is_cmd && addr_ok && cap_byte[6:5] == GRP_LISTEN && cap_byte[4:0] == my_addr;
  assign mta_hit = is_cmd && addr_ok && cap_byte[6:5] == GRP_TALK && cap_byte[4:0] == my_addr;
  assign gtl_hit = is_cmd && listener && cap_byte[6:0] == CMD_GTL;
  assign get_hit = is_cmd && listener && cap_byte[6:0] == CMD_GET;
  assign llo_hit = is_cmd && cap_byte[6:0] == CMD_LLO;
  assign clr_hit = is_cmd && (cap_byte[6:0] == CMD_DCL || (listener && cap_byte[6:0] == CMD_SDC));
  assign data_hit = (ah_state == AH_DECODE) && !cap_atn && listener && !busy;
  assign key_press = key_s && !key_d;
  assign trig_ok = trig_wait && trig_src_bus;
  assign term_hit = cap_byte == BYTE_LF || cap_eoi;
  // stall data bytes only; commands must still pass
  assign holdoff = busy && listener && !atn_s;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      key_d <= 1'b0;
    else
      key_d <= key_s;
  end

  // remote / local / lockout
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rl_state <= RL_LOCAL;
      llo_seen <= 1'b0;
    end
    else if (!ren_s)
    begin
      rl_state <= RL_LOCAL;
      llo_seen <= 1'b0;
    end
    else
    begin
      if (llo_hit)
        llo_seen <= 1'b1;
      case (rl_state)
        RL_LOCAL:
          if (mla_hit)
            rl_state <= (llo_seen || llo_hit) ? RL_LOCKOUT : RL_REMOTE;
        RL_REMOTE:
          if (gtl_hit || key_press)
            rl_state <= RL_LOCAL;
          else if (llo_hit)
            rl_state <= RL_LOCKOUT;
        RL_LOCKOUT:
          if (gtl_hit)
            rl_state <= RL_LOCAL;
        default:
          rl_state <= RL_LOCAL;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      remote_led <= 1'b0;
      lockout <= 1'b0;
      panel_keys_out <= 8'h00;
      local_req <= 1'b0;
    end
    else
    begin
      remote_led <= rl_state != RL_LOCAL;
      lockout <= rl_state == RL_LOCKOUT;
      panel_keys_out <= (rl_state == RL_LOCAL) ? keys_s : 8'h00;
      local_req <= key_press && rl_state == RL_REMOTE && ren_s;
    end
  end

  // listener / talker addressing
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      listener <= 1'b0;
      talker <= 1'b0;
    end
    else if (is_cmd)
    begin
      if (mla_hit)
        listener <= 1'b1;
      else if (cap_byte[6:0] == CMD_UNL)
        listener <= 1'b0;
      if (mta_hit)
        talker <= 1'b1;
      else if (cap_byte[6:0] == CMD_UNT || cap_byte[6:5] == GRP_TALK)
        talker <= 1'b0;
    end
  end

  // acceptor handshake
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ah_state <= AH_READY;
      cap_byte <= 8'h00;
      cap_atn <= 1'b0;
      cap_eoi <= 1'b0;
    end
    else
    begin
      case (ah_state)
        AH_READY:
          if (dav_s && !holdoff)
          begin
            cap_byte <= dio_s;
            cap_atn <= atn_s;
            cap_eoi <= eoi_s;
            ah_state <= AH_DECODE;
          end
        AH_DECODE:
          if (get_hit && trig_ok)
            ah_state <= AH_WAIT_START;
          else if (clr_hit)
            ah_state <= AH_WAIT_CLEAR;
          else
            ah_state <= AH_ACCEPT;
        AH_WAIT_START:
          if (start_done)
            ah_state <= AH_ACCEPT;
        AH_WAIT_CLEAR:
          if (clear_ack)
            ah_state <= AH_ACCEPT;
        AH_ACCEPT:
          if (!dav_s)
            ah_state <= AH_READY;
        default:
          ah_state <= AH_READY;
      endcase
    end
  end

  // open-drain lines only ever pull low
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ndac_out <= 1'b0;
      nrfd_out <= 1'b0;
      ndac_oe <= 1'b1;
      nrfd_oe <= 1'b1;
    end
    else
    begin
      ndac_out <= 1'b0;
      nrfd_out <= 1'b0;
      ndac_oe <= ah_state != AH_ACCEPT;
      nrfd_oe <= ah_state != AH_READY || holdoff;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meas_start <= 1'b0;
      meas_abort <= 1'b0;
      dev_clear <= 1'b0;
    end
    else
    begin
      meas_start <= get_hit && trig_ok;
      meas_abort <= clr_hit && meas_busy;
      dev_clear <= clr_hit;
    end
  end

  // receive buffer
  always_ff @(posedge clk)
  begin
    if (data_hit && wr_cnt < MSG_CAP)
      mem[wr_cnt] <= cap_byte;
    rd_data <= mem[rd_addr];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_cnt <= 8'h00;
      busy <= 1'b0;
      msg_len <= 8'h00;
      msg_ready <= 1'b0;
    end
    else if (clr_hit)
    begin
      wr_cnt <= 8'h00;
      busy <= 1'b0;
      msg_ready <= 1'b0;
    end
    else if (data_hit)
    begin
      if (wr_cnt < MSG_CAP)
        wr_cnt <= wr_cnt + 8'h01;
      if (term_hit)
      begin
        busy <= 1'b1;
        msg_ready <= 1'b1;
        msg_len <= (wr_cnt < MSG_CAP) ? wr_cnt + 8'h01 : wr_cnt;
      end
    end
    else if (busy && exec_done)
    begin
      busy <= 1'b0;
      msg_ready <= 1'b0;
      wr_cnt <= 8'h00;
    end
  end

  AST_PWR_LOCAL: assert property (@(posedge clk) disable iff (!resetn)
    !$past(resetn) |-> rl_state == RL_LOCAL && !remote_led)
    else $error("not local after reset");
  AST_LED: assert property (@(posedge clk) disable iff (!resetn)
    ##1 remote_led == ($past(rl_state) != RL_LOCAL))
    else $error("remote indicator wrong");
  AST_REN_FALSE: assert property (@(posedge clk) disable iff (!resetn)
    !ren_s |=> rl_state == RL_LOCAL && !llo_seen)
    else $error("ren false did not force local");
  AST_REMOTE_ENTRY: assert property (@(posedge clk) disable iff (!resetn)
    rl_state == RL_LOCAL ##1 rl_state != RL_LOCAL |-> $past(mla_hit) && $past(ren_s))
    else $error("remote entered without mla");
  AST_LOCKOUT_KEY: assert property (@(posedge clk) disable iff (!resetn)
    rl_state == RL_LOCKOUT && key_press && ren_s && !gtl_hit |=> rl_state == RL_LOCKOUT)
    else $error("local key left lockout");
  AST_GET_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    ah_state == AH_WAIT_START && !start_done |=> ah_state == AH_WAIT_START ##1 ndac_oe)
    else $error("ndac released before start done");
  AST_CLR_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    clr_hit |=> ah_state == AH_WAIT_CLEAR && dev_clear ##1 ndac_oe)
    else $error("clear not held");
  AST_GET_SKIP: assert property (@(posedge clk) disable iff (!resetn)
    get_hit && !trig_ok |=> !meas_start && ah_state == AH_ACCEPT)
    else $error("get started measurement wrongly");
  AST_CAP: assert property (@(posedge clk) disable iff (!resetn)
    wr_cnt == MSG_CAP && data_hit |=> wr_cnt == MSG_CAP)
    else $error("buffer overflowed");
  AST_HOLDOFF: assert property (@(posedge clk) disable iff (!resetn)
    holdoff && ah_state == AH_READY |=> nrfd_oe && ah_state == AH_READY)
    else $error("byte accepted while busy");
  AST_ABORT: assert property (@(posedge clk) disable iff (!resetn)
    clr_hit && meas_busy |=> meas_abort)
    else $error("measurement not stopped");
endmodule

// ===== design/grl_pkg.sv
// Functional notes
// - power-up enters local state, panel keys in control, remote indicator dark
// - remote indicator lit in remote or lockout, dark in local
// - local key returns remote (not locked out) device to local
// - GTL while addressed as listener returns device to local
// - remote entered only on own listen address while REN true
// - in remote every panel key except local key is ignored
// - LLO received in remote enters local-lockout
// - entering remote after an earlier LLO lands in lockout
// - lockout ignores local key, otherwise acts as remote
// - GTL leaves lockout for local; remembered lockout persists
// - remembered lockout cleared only by power cycle or REN false
// - GET starts measurement only when waiting for trigger with bus source
// - after GET, NDAC held until measurement start completes
// - DCL, or SDC as listener, aborts transfer, clears buffers and MAV
// - DCL or SDC during measurement stops it into hold
// - after DCL or SDC, NDAC held until processor acknowledges
// - interpretation starts at message end: delimiter byte or EOI
// - while interpreting, first byte of next message is held off
// - own address 0 to 30 serves as listen and talk address
// - LF, CR then LF, or EOI each terminate a received message
// - receive buffer holds 255 bytes with delimiter; excess discarded
package grl_pkg;
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [6:0] CMD_UNT = 7'h5f;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [4:0] ADDR_MAX = 5'h1e;
  localparam logic [7:0] BYTE_LF = 8'h0a;
  localparam logic [7:0] MSG_CAP = 8'hff;
  localparam int SYNC_W = 21;
  // dio_n, dav_n, atn_n, eoi_n, ren_n idle high; keys idle low
  localparam logic [20:0] SYNC_INIT = 21'h1ffe00;
  typedef enum logic [1:0] {RL_LOCAL, RL_REMOTE, RL_LOCKOUT} grl_rl_t;
  typedef enum logic [2:0] {AH_READY, AH_DECODE, AH_WAIT_START, AH_WAIT_CLEAR, AH_ACCEPT} grl_ah_t;
endpackage

// ===== design/grl_sync.sv
`timescale 1ns/1ps
module grl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          meta[i] <= INIT[i];
          q[i] <= INIT[i];
        end
        else
        begin
          meta[i] <= d[i];
          q[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule

// ===== sim/grl_ctrl_model.sv
`timescale 1ns/1ps
module grl_ctrl_model (
  input wire logic clk,
  input wire logic ndac_oe,
  input wire logic nrfd_oe,
  output logic [7:0] dio_n,
  output logic dav_n,
  output logic atn_n,
  output logic eoi_n,
  output logic ren_n
);
  int taken = 0;
  initial
  begin
    dio_n = 8'hff;
    {dav_n, atn_n, eoi_n, ren_n} = 4'hf;
  end
  // ren is raised before any addressing is sent
  task automatic set_ren(input logic on);
    @(posedge clk);
    ren_n <= !on;
  endtask
  // one source handshake, bounded waits for ready and accept
  task automatic put(input logic [7:0] b, input logic atn, input logic eoi);
    int i;
    i = 0;
    @(posedge clk);
    while (nrfd_oe !== 1'b0 && i < 3000)
    begin
      @(posedge clk);
      i++;
    end
    dio_n <= ~b;
    atn_n <= !atn;
    eoi_n <= !eoi;
    @(posedge clk);
    dav_n <= 1'b0;
    i = 0;
    while (ndac_oe !== 1'b0 && i < 3000)
    begin
      @(posedge clk);
      i++;
    end
    dav_n <= 1'b1;
    taken++;
    @(posedge clk);
    // released lines float back to the idle high level of the terminations
    dio_n <= 8'hff;
    {atn_n, eoi_n} <= 2'h3;
  endtask
endmodule

// ===== sim/gpib_remote_local_control_tb_top.sv
`timescale 1ns/1ps
module gpib_remote_local_control_tb_top;
  import grl_pkg::*;
  logic clk = 0, resetn = 0, local_key = 0, trig_wait = 0, trig_src_bus = 0;
  logic meas_busy = 0, start_done = 1, clear_ack = 1, exec_done = 0;
  logic [4:0] my_addr = 5'h1e;
  logic [7:0] panel_keys = 8'h00, rd_addr = 8'h00;
  logic [7:0] dio_n, rd_data, msg_len, panel_keys_out;
  logic dav_n, atn_n, eoi_n, ren_n, ndac_out, ndac_oe, nrfd_out, nrfd_oe, msg_ready, remote_led;
  logic lockout, listener, talker, local_req, meas_start, meas_abort, dev_clear;
  logic [7:0] exp_buf [0:299];
  int errors = 0, checked = 0, seed = 49, cyc = 0, n_st = 0, n_ab = 0, n_cl = 0, n_lr = 0, base = 0;
  grl_port grl_port_inst (.clk, .resetn, .dio_n, .dav_n, .atn_n, .eoi_n, .ren_n, .ndac_out, .ndac_oe,
    .nrfd_out, .nrfd_oe, .my_addr, .local_key, .panel_keys, .trig_wait, .trig_src_bus, .meas_busy,
    .start_done, .clear_ack, .exec_done, .rd_addr, .rd_data, .msg_len, .msg_ready, .remote_led,
    .lockout, .listener, .talker, .panel_keys_out, .local_req, .meas_start, .meas_abort, .dev_clear);
  grl_ctrl_model grl_ctrl_model_inst (.clk, .ndac_oe, .nrfd_oe, .dio_n, .dav_n, .atn_n, .eoi_n, .ren_n);
  initial
  begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    n_st += (meas_start === 1'b1);
    n_ab += (meas_abort === 1'b1);
    n_cl += (dev_clear === 1'b1);
    n_lr += (local_req === 1'b1);
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmd(input logic [6:0] c);
    grl_ctrl_model_inst.put({1'b0, c}, 1'b1, 1'b0);
  endtask
  task automatic dat(input logic [7:0] b, input logic e);
    grl_ctrl_model_inst.put(b, 1'b0, e);
  endtask
  task automatic key();
    @(posedge clk);
    local_key <= 1'b1;
    repeat (4) @(posedge clk);
    local_key <= 1'b0;
    w(6);
  endtask
  task automatic exec();
    @(posedge clk);
    exec_done <= 1'b1;
    @(posedge clk);
    exec_done <= 1'b0;
  endtask
  // mode 0 ends in lf, 1 in cr lf, 2 with eoi on the last byte
  task automatic msg(input int len, input int mode);
    logic [7:0] b;
    int i, c;
    for (i = 0; i < len; i++)
    begin
      b = 8'($random(seed));
      if (b == BYTE_LF)
        b = 8'h41;
      if (mode != 2 && i == len - 1)
        b = BYTE_LF;
      if (mode == 1 && i == len - 2)
        b = 8'h0d;
      exp_buf[i] = b;
      dat(b, mode == 2 && i == len - 1);
    end
    w(3);
    chk("msg_ready", 1, msg_ready);
    chk("msg_len", len > 255 ? 255 : len, msg_len);
    for (i = 0; i < (len > 255 ? 255 : len); i++)
    begin
      @(posedge clk);
      rd_addr <= 8'(i);
      w(1);
      chk("rd_data", exp_buf[i], rd_data);
    end
    c = grl_ctrl_model_inst.taken;
    fork
      dat(BYTE_LF, 1'b0);
      begin
        w(12);
        chk("held_byte", 0, grl_ctrl_model_inst.taken - c);
        exec();
      end
    join
    w(3);
    chk("msg_len", 1, msg_len);
    exec();
    w(2);
    chk("msg_ready", 0, msg_ready);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    w(4);
    chk("remote_led", 0, remote_led);
    @(posedge clk);
    panel_keys <= 8'($random(seed)) | 8'h01;
    w(5);
    chk("panel_keys_out", panel_keys, panel_keys_out);
    grl_ctrl_model_inst.set_ren(1'b1);
    cmd({GRP_LISTEN, my_addr - 5'h1});
    w(2);
    chk("remote_led", 0, remote_led);
    cmd({GRP_LISTEN, my_addr});
    w(2);
    chk("remote_led", 1, remote_led);
    chk("listener", 1, listener);
    chk("panel_keys_out", 0, panel_keys_out);
    key();
    chk("remote_led", 0, remote_led);
    chk("local_req", 1, n_lr);
    cmd({GRP_LISTEN, my_addr});
    cmd(CMD_LLO);
    w(2);
    chk("lockout", 1, lockout);
    key();
    chk("remote_led", 1, remote_led);
    chk("local_req", 1, n_lr);
    cmd(CMD_GTL);
    w(2);
    chk("remote_led", 0, remote_led);
    cmd({GRP_LISTEN, my_addr});
    w(2);
    chk("lockout", 1, lockout);
    grl_ctrl_model_inst.set_ren(1'b0);
    w(4);
    chk("remote_led", 0, remote_led);
    @(posedge clk);
    my_addr <= 5'($unsigned($random(seed)) % 31);
    grl_ctrl_model_inst.set_ren(1'b1);
    cmd({GRP_LISTEN, my_addr});
    w(2);
    chk("lockout", 0, lockout);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      trig_wait <= k[0];
      trig_src_bus <= k[1];
      start_done <= 1'b0;
      base = grl_ctrl_model_inst.taken;
      fork
        cmd(CMD_GET);
        begin
          w(14);
          chk("get_done", k != 3, grl_ctrl_model_inst.taken - base);
          @(posedge clk);
          start_done <= 1'b1;
        end
      join
      w(2);
      chk("meas_start", k == 3, n_st);
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      meas_busy <= 1'b1;
      clear_ack <= 1'b0;
      dat(8'h41, 1'b0);
      base = grl_ctrl_model_inst.taken;
      fork
        cmd(k ? CMD_SDC : CMD_DCL);
        begin
          w(14);
          chk("clear_done", 0, grl_ctrl_model_inst.taken - base);
          @(posedge clk);
          clear_ack <= 1'b1;
        end
      join
      w(2);
      chk("dev_clear", k + 1, n_cl);
      chk("meas_abort", k + 1, n_ab);
    end
    for (int k = 0; k < 4; k++)
      msg(k == 3 ? 260 : 2 + $unsigned($random(seed)) % 16, k == 3 ? 2 : k);
    cmd({GRP_TALK, my_addr});
    w(2);
    chk("talker", 1, talker);
    chk("ndac_out", 0, ndac_out);
    chk("nrfd_out", 0, nrfd_out);
    report_and_stop();
  end
endmodule
